/* File: common/cha_pkg.sv */
// Functional notes
// - Control bit 11 picks gate turn-on delay: 0 gives 1.3 s, 1 gives 150 ms.
// - First adapter insertion after power-on uses the 150 ms gate delay, unless reverse-supply mode already turned the gate on and off.
// - Bit 11 delay applies only after the gate has turned off once.
// - Bits 10:9 set input and discharge alert debounce: 10us,100us,500us,1ms.
// - Low-rail alert always debounces for a fixed 10 us.
// - Throttle alert stays asserted at least the time chosen by bits 8:6.
// - In reverse-supply mode bit 5 low turns the gate on, high off.
// - Bit 4 picks comparator reference: 0 is 1.2 V, 1 is 2 V.
// - Bit 3 low enables the general comparator, high disables it.
// - Bit 2 low: output high when input above reference; high inverts it.
// - Bit 1 low keeps severe-overcurrent protection active, high disables it.
// - Bit 0 picks power monitor gain: 0 is 1.44 uA/W, 1 is 0.36 uA/W.
// - Voltage setpoint stores only bits 12:7, the rest is dropped.
// - Voltage bits 7..12 weigh 128 mV up to 4096 mV, summed.
// - Voltage field clamps between 100110 (4.864 V) and 101010 (5.376 V).
// - Current bits 7..12 weigh 128 mA up to 4096 mA; others ignored.
// - Current field stores valid bits only and clamps at 100000 (4096 mA).
package cha_pkg;

  typedef logic [27:0] cha_cnt_t;
  typedef logic [5:0] cha_fld_t;

  // Command codes of the registers
  localparam logic [7:0] CHA_REG_CTRL2 = 8'h3d;
  localparam logic [7:0] CHA_REG_VSET = 8'h49;
  localparam logic [7:0] CHA_REG_ILIM = 8'h4a;

  // Control word bit positions
  localparam int CHA_B_GATE_SEL = 11;
  localparam int CHA_F_DEB_LO = 9;
  localparam int CHA_F_HOLD_LO = 6;
  localparam int CHA_B_REV_GATE = 5;
  localparam int CHA_B_CMP_REF = 4;
  localparam int CHA_B_CMP_DIS = 3;
  localparam int CHA_B_CMP_POL = 2;
  localparam int CHA_B_OCP_DIS = 1;
  localparam int CHA_B_GAIN = 0;
  // Setpoint field position inside the data word
  localparam int CHA_F_SET_LO = 7;
  localparam int CHA_F_SET_HI = 12;

  // Reset values and clamp limits
  localparam logic [15:0] CHA_CTRL2_RST = 16'h0000;
  localparam cha_fld_t CHA_VSET_MIN = 6'h26;
  localparam cha_fld_t CHA_VSET_MAX = 6'h2a;
  localparam cha_fld_t CHA_ILIM_MAX = 6'h20;
  localparam cha_fld_t CHA_VSET_RST = CHA_VSET_MIN;
  localparam cha_fld_t CHA_ILIM_RST = 6'h00;

  // Debounce channel indices
  localparam int CHA_CH_IN = 0;
  localparam int CHA_CH_DIS = 1;
  localparam int CHA_CH_LOW = 2;
  localparam int CHA_CH_GATE = 3;
  localparam int CHA_NCH = 4;

  // Times in microseconds and their cycle counts
  localparam int CHA_CLK_MHZ = 100;
  localparam int CHA_GATE_SLOW_US = 1300000;
  localparam int CHA_GATE_FAST_US = 150000;
  localparam int CHA_T10US_US = 10;
  localparam int CHA_T100US_US = 100;
  localparam int CHA_T500US_US = 500;
  localparam int CHA_T1MS_US = 1000;
  localparam int CHA_T5MS_US = 5000;
  localparam int CHA_T10MS_US = 10000;
  localparam int CHA_T15MS_US = 15000;
  localparam int CHA_T20MS_US = 20000;
  localparam int CHA_GATE_SLOW_CYC = CHA_GATE_SLOW_US * CHA_CLK_MHZ;
  localparam int CHA_GATE_FAST_CYC = CHA_GATE_FAST_US * CHA_CLK_MHZ;
  localparam int CHA_T10US_CYC = CHA_T10US_US * CHA_CLK_MHZ;
  localparam int CHA_T100US_CYC = CHA_T100US_US * CHA_CLK_MHZ;
  localparam int CHA_T500US_CYC = CHA_T500US_US * CHA_CLK_MHZ;
  localparam int CHA_T1MS_CYC = CHA_T1MS_US * CHA_CLK_MHZ;
  localparam int CHA_T5MS_CYC = CHA_T5MS_US * CHA_CLK_MHZ;
  localparam int CHA_T10MS_CYC = CHA_T10MS_US * CHA_CLK_MHZ;
  localparam int CHA_T15MS_CYC = CHA_T15MS_US * CHA_CLK_MHZ;
  localparam int CHA_T20MS_CYC = CHA_T20MS_US * CHA_CLK_MHZ;

endpackage

/* File: common/cha_deb_if.sv */
// Condition, delay and result of one debounce timer
interface cha_deb_if;
  import cha_pkg::*;
  logic cond;
  cha_cnt_t delay;
  logic fired;
  modport owner (output cond, output delay, input fired);
  modport timer (input cond, input delay, output fired);
endinterface

/* File: design/cha_debounce.sv */
// Counts cycles of a held condition and fires once the delay is reached
module cha_debounce
  import cha_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  cha_deb_if.timer db
);

  cha_cnt_t cnt_q;
  logic fired_q;

  // Count while held, restart on any drop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
    end else if (!db.cond) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
    end else if (cnt_q >= db.delay) begin
      fired_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 28'h0000001;
    end
  end

  assign db.fired = fired_q;

  // A drop clears both count and result
  chk_restart_on_drop: assert property (@(posedge mclk) disable iff (rst)
    !db.cond |=> (cnt_q == '0) && !fired_q)
    else $error("debounce did not restart after condition dropped");

endmodule // cha_debounce

/* File: design/cha_regs.sv */
// Charger control, alert debounce and reverse-supply setpoint registers
module cha_regs
  import cha_pkg::*;
#(
  parameter int unsigned P_GATE_SLOW = CHA_GATE_SLOW_CYC,
  parameter int unsigned P_GATE_FAST = CHA_GATE_FAST_CYC,
  parameter int unsigned P_100US = CHA_T100US_CYC,
  parameter int unsigned P_500US = CHA_T500US_CYC,
  parameter int unsigned P_1MS = CHA_T1MS_CYC,
  parameter int unsigned P_5MS = CHA_T5MS_CYC,
  parameter int unsigned P_10MS = CHA_T10MS_CYC,
  parameter int unsigned P_15MS = CHA_T15MS_CYC,
  parameter int unsigned P_20MS = CHA_T20MS_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_valid,
  input wire logic [7:0] wr_code,
  input wire logic [15:0] wr_data,
  input wire logic rd_req,
  input wire logic [7:0] rd_code,
  output logic [15:0] rd_data,
  output logic rd_ack,
  input wire logic adapter_present,
  input wire logic reverse_supply_mode,
  input wire logic input_current_cond,
  input wire logic discharge_current_cond,
  input wire logic low_rail_cond,
  input wire logic comparator_above,
  input wire logic overcurrent_raw,
  output logic adapter_switch_gate,
  output logic input_current_alert,
  output logic discharge_current_alert,
  output logic low_rail_alert,
  output logic throttle_alert_n_o,
  output logic throttle_alert_n_oe,
  output logic comparator_output,
  output logic comparator_ref_high,
  output logic comparator_enable,
  output logic severe_overcurrent_protection,
  output logic overcurrent_trip,
  output logic platform_power_monitor_low_gain,
  output logic [12:0] reverse_voltage_mv,
  output logic [12:0] reverse_current_ma
);

  localparam cha_cnt_t C_10US = cha_cnt_t'(CHA_T10US_CYC);
  localparam cha_cnt_t C_100US = cha_cnt_t'(P_100US);
  localparam cha_cnt_t C_500US = cha_cnt_t'(P_500US);
  localparam cha_cnt_t C_1MS = cha_cnt_t'(P_1MS);
  localparam cha_cnt_t C_5MS = cha_cnt_t'(P_5MS);
  localparam cha_cnt_t C_10MS = cha_cnt_t'(P_10MS);
  localparam cha_cnt_t C_15MS = cha_cnt_t'(P_15MS);
  localparam cha_cnt_t C_20MS = cha_cnt_t'(P_20MS);
  localparam cha_cnt_t C_SLOW = cha_cnt_t'(P_GATE_SLOW);
  localparam cha_cnt_t C_FAST = cha_cnt_t'(P_GATE_FAST);

  logic [15:0] ctrl_q;
  cha_fld_t vset_q;
  cha_fld_t ilim_q;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic adapter_s;
  logic in_s;
  logic dis_s;
  logic low_s;
  logic cmp_s;
  logic ocp_s;
  cha_fld_t vset_in;
  cha_fld_t ilim_in;
  cha_fld_t vset_d;
  cha_fld_t ilim_d;
  cha_cnt_t deb_dly;
  cha_cnt_t gate_dly;
  cha_cnt_t hold_dly;
  cha_cnt_t hold_q;
  logic alert_q;
  logic any_fired;
  logic gate_q;
  logic gate_d;
  logic off_seen_q;
  logic cmp_q;
  logic [15:0] rd_data_q;
  logic rd_ack_q;
  logic [CHA_NCH-1:0] ch_cond;
  cha_cnt_t ch_dly [CHA_NCH];
  logic [CHA_NCH-1:0] ch_fired;

  // Two-flop synchronisers for all pin inputs except reverse_supply_mode
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {overcurrent_raw, comparator_above, low_rail_cond,
                  discharge_current_cond, input_current_cond, adapter_present};
      sync2_q <= sync1_q;
    end
  end

  assign adapter_s = sync2_q[0];
  assign in_s = sync2_q[1];
  assign dis_s = sync2_q[2];
  assign low_s = sync2_q[3];
  assign cmp_s = sync2_q[4];
  assign ocp_s = sync2_q[5];

  // Write data reduced to the stored field and clamped
  assign vset_in = wr_data[CHA_F_SET_HI:CHA_F_SET_LO];
  assign ilim_in = wr_data[CHA_F_SET_HI:CHA_F_SET_LO];
  always_comb begin
    if (vset_in > CHA_VSET_MAX) begin
      vset_d = CHA_VSET_MAX;
    end else if (vset_in < CHA_VSET_MIN) begin
      vset_d = CHA_VSET_MIN;
    end else begin
      vset_d = vset_in;
    end
    ilim_d = (ilim_in > CHA_ILIM_MAX) ? CHA_ILIM_MAX : ilim_in;
  end

  // Write-word decode, one register per command code
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CHA_CTRL2_RST;
      vset_q <= CHA_VSET_RST;
      ilim_q <= CHA_ILIM_RST;
    end else if (wr_valid) begin
      case (wr_code)
        CHA_REG_CTRL2: ctrl_q <= wr_data;
        CHA_REG_VSET: vset_q <= vset_d;
        CHA_REG_ILIM: ilim_q <= ilim_d;
        default: ;
      endcase
    end
  end

  // Read-word answer one cycle after the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_req;
      if (rd_req) begin
        case (rd_code)
          CHA_REG_CTRL2: rd_data_q <= ctrl_q;
          CHA_REG_VSET: rd_data_q <= {3'h0, vset_q, 7'h00};
          CHA_REG_ILIM: rd_data_q <= {3'h0, ilim_q, 7'h00};
          default: rd_data_q <= 16'h0000;
        endcase
      end
    end
  end

  assign rd_data = rd_data_q;
  assign rd_ack = rd_ack_q;

  // Setpoints as binary weighted sums of 128 units per step
  assign reverse_voltage_mv = {vset_q, 7'h00};
  assign reverse_current_ma = {ilim_q, 7'h00};

  // Alert debounce selection
  always_comb begin
    case (ctrl_q[CHA_F_DEB_LO +: 2])
      2'b00: deb_dly = C_10US;
      2'b01: deb_dly = C_100US;
      2'b10: deb_dly = C_500US;
      2'b11: deb_dly = C_1MS;
      default: deb_dly = C_10US;
    endcase
  end

  // Minimum throttle duration selection
  always_comb begin
    case (ctrl_q[CHA_F_HOLD_LO +: 3])
      3'b000: hold_dly = C_10MS;
      3'b001: hold_dly = C_20MS;
      3'b010: hold_dly = C_15MS;
      3'b011: hold_dly = C_5MS;
      3'b100: hold_dly = C_1MS;
      3'b101: hold_dly = C_500US;
      3'b110: hold_dly = C_100US;
      3'b111: hold_dly = '0;
      default: hold_dly = C_10MS;
    endcase
  end

  // Gate delay: fast until the gate has been off once
  assign gate_dly = !off_seen_q ? C_FAST :
                    (ctrl_q[CHA_B_GATE_SEL] ? C_FAST : C_SLOW);

  // Channel conditions and delays
  assign ch_cond[CHA_CH_IN] = in_s;
  assign ch_cond[CHA_CH_DIS] = dis_s;
  assign ch_cond[CHA_CH_LOW] = low_s;
  assign ch_cond[CHA_CH_GATE] = adapter_s && !reverse_supply_mode;
  assign ch_dly[CHA_CH_IN] = deb_dly;
  assign ch_dly[CHA_CH_DIS] = deb_dly;
  assign ch_dly[CHA_CH_LOW] = C_10US;
  assign ch_dly[CHA_CH_GATE] = gate_dly;

  // One debounce timer per channel
  for (genvar i = 0; i < CHA_NCH; i++) begin : g_deb
    cha_deb_if dbi ();
    assign dbi.cond = ch_cond[i];
    assign dbi.delay = ch_dly[i];
    assign ch_fired[i] = dbi.fired;
    cha_debounce u_deb (
      .mclk(mclk),
      .rst(rst),
      .db(dbi)
    );
  end

  assign input_current_alert = ch_fired[CHA_CH_IN];
  assign discharge_current_alert = ch_fired[CHA_CH_DIS];
  assign low_rail_alert = ch_fired[CHA_CH_LOW];
  assign any_fired = ch_fired[CHA_CH_IN] | ch_fired[CHA_CH_DIS] | ch_fired[CHA_CH_LOW];

  // Throttle alert with minimum assertion time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alert_q <= 1'b0;
      hold_q <= '0;
    end else if (!alert_q) begin
      if (any_fired) begin
        alert_q <= 1'b1;
        hold_q <= hold_dly;
      end
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 28'h0000001;
    end else if (!any_fired) begin
      alert_q <= 1'b0;
    end
  end

  // Open-drain throttle pin pulls low while asserted
  assign throttle_alert_n_o = 1'b0;
  assign throttle_alert_n_oe = alert_q;

  // Gate drive, forced by bit 5 in reverse-supply mode
  assign gate_d = reverse_supply_mode ? !ctrl_q[CHA_B_REV_GATE]
                                      : ch_fired[CHA_CH_GATE];
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  // Remember that the gate has turned off since power-on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      off_seen_q <= 1'b0;
    end else if (gate_q && !gate_d) begin
      off_seen_q <= 1'b1;
    end
  end

  assign adapter_switch_gate = gate_q;

  // General comparator with enable and polarity
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmp_q <= 1'b0;
    end else begin
      cmp_q <= !ctrl_q[CHA_B_CMP_DIS] && (cmp_s ^ ctrl_q[CHA_B_CMP_POL]);
    end
  end

  assign comparator_output = cmp_q;
  assign comparator_ref_high = ctrl_q[CHA_B_CMP_REF];
  assign comparator_enable = !ctrl_q[CHA_B_CMP_DIS];
  assign severe_overcurrent_protection = !ctrl_q[CHA_B_OCP_DIS];
  assign overcurrent_trip = ocp_s && !ctrl_q[CHA_B_OCP_DIS];
  assign platform_power_monitor_low_gain = ctrl_q[CHA_B_GAIN];

  // Write to the voltage register ends within the clamp range
  sequence s_vset_write;
    wr_valid && (wr_code == CHA_REG_VSET);
  endsequence
  chk_vset_clamp_range: assert property (@(posedge mclk) disable iff (rst)
    s_vset_write |=> (vset_q >= CHA_VSET_MIN) && (vset_q <= CHA_VSET_MAX)
      && (vset_q == (($past(wr_data[12:7]) > CHA_VSET_MAX) ? CHA_VSET_MAX
                     : ($past(wr_data[12:7]) < CHA_VSET_MIN) ? CHA_VSET_MIN
                     : $past(wr_data[12:7]))))
    else $error("voltage setpoint not clamped");

  chk_ilim_clamp_max: assert property (@(posedge mclk) disable iff (rst)
    (wr_valid && wr_code == CHA_REG_ILIM) |=> (ilim_q <= CHA_ILIM_MAX)
      && (ilim_q == (($past(wr_data[12:7]) > CHA_ILIM_MAX) ? CHA_ILIM_MAX
                     : $past(wr_data[12:7]))))
    else $error("current limit not stored or clamped");

  chk_setpoint_weights: assert property (@(posedge mclk) disable iff (rst)
    (reverse_voltage_mv == vset_q * 13'd128) && (reverse_current_ma == ilim_q * 13'd128))
    else $error("setpoint weights wrong");

  chk_gate_delay_sel: assert property (@(posedge mclk) disable iff (rst)
    (!off_seen_q |-> gate_dly == C_FAST) and
    (off_seen_q |-> gate_dly == (ctrl_q[11] ? C_FAST : C_SLOW)))
    else $error("gate turn-on delay selection wrong");

  chk_alert_debounce: assert property (@(posedge mclk) disable iff (rst)
    (ch_dly[CHA_CH_LOW] == C_10US) &&
    (ch_dly[CHA_CH_IN] == ((ctrl_q[10:9] == 2'b00) ? C_10US :
                           (ctrl_q[10:9] == 2'b01) ? C_100US :
                           (ctrl_q[10:9] == 2'b10) ? C_500US : C_1MS)))
    else $error("alert debounce delay wrong");

  // Throttle alert is loaded on assertion and only releases when drained
  sequence s_throttle_rise;
    $rose(alert_q);
  endsequence
  chk_throttle_load: assert property (@(posedge mclk) disable iff (rst)
    s_throttle_rise |-> hold_q == $past(hold_dly))
    else $error("throttle hold not loaded");
  chk_throttle_hold: assert property (@(posedge mclk) disable iff (rst)
    $fell(alert_q) |-> ($past(hold_q) == '0) && !$past(any_fired))
    else $error("throttle released early");

  chk_rev_gate_drive: assert property (@(posedge mclk) disable iff (rst)
    reverse_supply_mode |=> adapter_switch_gate == !$past(ctrl_q[5]))
    else $error("gate wrong in reverse-supply mode");

  chk_cmp_output: assert property (@(posedge mclk) disable iff (rst)
    ##1 comparator_output == (!$past(ctrl_q[CHA_B_CMP_DIS])
      && ($past(cmp_s) ^ $past(ctrl_q[CHA_B_CMP_POL]))))
    else $error("comparator output wrong");

  chk_ocp_gate: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[1] |-> !overcurrent_trip)
    else $error("overcurrent trip while protection disabled");

  // Setpoint reads show the stored field and nothing else
  sequence s_setpoint_read;
    rd_req && ((rd_code == CHA_REG_VSET) || (rd_code == CHA_REG_ILIM));
  endsequence
  chk_read_field: assert property (@(posedge mclk) disable iff (rst)
    s_setpoint_read |=> rd_ack && (rd_data[15:13] == 3'h0) && (rd_data[6:0] == 7'h00))
    else $error("setpoint read shows unused bits");

  // A debounced alert asserts the throttle pin on the next edge
  chk_throttle_follows: assert property (@(posedge mclk) disable iff (rst)
    any_fired |=> throttle_alert_n_oe)
    else $error("throttle pin not asserted for a debounced alert");

endmodule // cha_regs

/* File: bench/cha_host.sv */
// Host side of the decoded write-word and read-word port
module cha_host (
  input wire logic mclk,
  output logic wr_valid,
  output logic [7:0] wr_code,
  output logic [15:0] wr_data,
  output logic rd_req,
  output logic [7:0] rd_code,
  input wire logic [15:0] rd_data,
  input wire logic rd_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    wr_valid = 1'b0;
    wr_code = 8'h00;
    wr_data = 16'h0000;
    rd_req = 1'b0;
    rd_code = 8'h00;
  end

  // One write-word, a command code and a full 16-bit word
  task automatic write_word(input logic [7:0] c, input logic [15:0] d);
    @(negedge mclk);
    wr_valid = 1'b1;
    wr_code = c;
    wr_data = d;
    @(negedge mclk);
    wr_valid = 1'b0;
    wr_code = ~c; // Released lines do not keep the last value
    wr_data = ~d;
  endtask

  // One read, answer taken in the cycle after the request
  task automatic read_word(input logic [7:0] c, output logic [15:0] d, output logic a);
    @(negedge mclk);
    rd_req = 1'b1;
    rd_code = c;
    @(negedge mclk);
    d = rd_data;
    a = rd_ack;
    rd_req = 1'b0;
    rd_code = ~c;
  endtask
endmodule // cha_host

/* File: bench/tb_top.sv */
// Compare and count one value
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top
  import cha_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int G_SLOW = 200;
  localparam int G_FAST = 100;
  localparam int T100 = 20;
  localparam int T500 = 40;
  localparam int T1M = 60;
  int dur_tab[8] = '{120, 180, 150, 80, 60, 40, 20, 0};
  int deb_tab[4] = '{CHA_T10US_CYC, T100, T500, T1M};
  logic [15:0] corner[4] = '{16'hffff, 16'h0000, 16'h1380, 16'h0f80};

  logic mclk, rst, wr_valid, rd_req, rd_ack;
  logic [7:0] wr_code, rd_code;
  logic [15:0] wr_data, rd_data, d;
  logic adapter_present, reverse_supply_mode, input_current_cond, discharge_current_cond;
  logic low_rail_cond, comparator_above, overcurrent_raw;
  logic adapter_switch_gate, input_current_alert, discharge_current_alert, low_rail_alert;
  logic throttle_alert_n_o, throttle_alert_n_oe, comparator_output, comparator_ref_high;
  logic comparator_enable, severe_overcurrent_protection, overcurrent_trip;
  logic platform_power_monitor_low_gain;
  logic [12:0] reverse_voltage_mv, reverse_current_ma;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 98;
  int n;
  // Open-drain alert pin with pull-up
  wire throttle_pin_n = throttle_alert_n_oe ? throttle_alert_n_o : 1'b1;

  cha_host cha_host_inst (.mclk(mclk), .wr_valid(wr_valid), .wr_code(wr_code),
    .wr_data(wr_data), .rd_req(rd_req), .rd_code(rd_code), .rd_data(rd_data), .rd_ack(rd_ack));

  cha_regs #(.P_GATE_SLOW(G_SLOW), .P_GATE_FAST(G_FAST), .P_100US(T100), .P_500US(T500),
    .P_1MS(T1M), .P_5MS(80), .P_10MS(120), .P_15MS(150), .P_20MS(180)) cha_regs_inst (
    .mclk(mclk), .rst(rst), .wr_valid(wr_valid), .wr_code(wr_code), .wr_data(wr_data),
    .rd_req(rd_req), .rd_code(rd_code), .rd_data(rd_data), .rd_ack(rd_ack),
    .adapter_present(adapter_present), .reverse_supply_mode(reverse_supply_mode),
    .input_current_cond(input_current_cond), .discharge_current_cond(discharge_current_cond),
    .low_rail_cond(low_rail_cond), .comparator_above(comparator_above),
    .overcurrent_raw(overcurrent_raw), .adapter_switch_gate(adapter_switch_gate),
    .input_current_alert(input_current_alert), .discharge_current_alert(discharge_current_alert),
    .low_rail_alert(low_rail_alert), .throttle_alert_n_o(throttle_alert_n_o),
    .throttle_alert_n_oe(throttle_alert_n_oe), .comparator_output(comparator_output),
    .comparator_ref_high(comparator_ref_high), .comparator_enable(comparator_enable),
    .severe_overcurrent_protection(severe_overcurrent_protection),
    .overcurrent_trip(overcurrent_trip),
    .platform_power_monitor_low_gain(platform_power_monitor_low_gain),
    .reverse_voltage_mv(reverse_voltage_mv), .reverse_current_ma(reverse_current_ma));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Expected clamped fields
  function automatic logic [5:0] vexp(logic [15:0] w);
    logic [5:0] f;
    f = w[12:7];
    return (f < CHA_VSET_MIN) ? CHA_VSET_MIN : (f > CHA_VSET_MAX) ? CHA_VSET_MAX : f;
  endfunction
  function automatic logic [5:0] iexp(logic [15:0] w);
    return (w[12:7] > CHA_ILIM_MAX) ? CHA_ILIM_MAX : w[12:7];
  endfunction

  // Observed level selected by index
  function automatic logic pick(int w);
    case (w)
      0: return input_current_alert;
      1: return discharge_current_alert;
      2: return low_rail_alert;
      3: return adapter_switch_gate;
      4: return !adapter_switch_gate;
      5: return !throttle_pin_n;
      default: return throttle_pin_n;
    endcase
  endfunction

  task automatic cyc(int k);
    repeat (k) @(negedge mclk);
  endtask
  // Count falling edges until the picked level is high
  task automatic wait_hi(int w, int lim, output int cnt);
    cnt = 0;
    while (pick(w) !== 1'b1 && cnt < lim) begin
      @(negedge mclk);
      cnt++;
    end
  endtask
  task automatic win(int cnt, int lo, int hi);
    `CHK(cnt >= lo && cnt <= hi, 1'b1)
  endtask
  task automatic rd_chk(logic [7:0] c, logic [15:0] e);
    logic [15:0] got;
    logic ack;
    cha_host_inst.read_word(c, got, ack);
    `CHK(ack, 1'b1)
    `CHK(got, e)
  endtask
  task automatic wr(logic [7:0] c, logic [15:0] w);
    cha_host_inst.write_word(c, w);
  endtask

  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #600000;
    miscompares++;
    stop_test();
  end

  // Main sequence
  initial begin
    {adapter_present, reverse_supply_mode, input_current_cond, discharge_current_cond} = 4'h0;
    {low_rail_cond, comparator_above, overcurrent_raw} = 3'h0;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(2);
    // Values after reset
    `CHK(comparator_enable, 1'b1)
    `CHK(severe_overcurrent_protection, 1'b1)
    `CHK(platform_power_monitor_low_gain, 1'b0)
    `CHK(comparator_ref_high, 1'b0)
    `CHK(reverse_voltage_mv, 13'd4864)
    rd_chk(CHA_REG_CTRL2, 16'h0000);
    rd_chk(CHA_REG_VSET, 16'h1300);
    rd_chk(8'h3a, 16'h0000);
    wr(8'h3a, 16'hffff);
    rd_chk(CHA_REG_CTRL2, 16'h0000);
    rd_chk(CHA_REG_VSET, 16'h1300);
    // Setpoints: corners then random words
    for (int i = 0; i < 24; i++) begin
      d = (i < 4) ? corner[i] : 16'($random(seed));
      wr(CHA_REG_VSET, d);
      rd_chk(CHA_REG_VSET, {3'h0, vexp(d), 7'h00});
      `CHK(reverse_voltage_mv, {vexp(d), 7'h00})
      wr(CHA_REG_ILIM, d);
      rd_chk(CHA_REG_ILIM, {3'h0, iexp(d), 7'h00});
      `CHK(reverse_current_ma, {iexp(d), 7'h00})
    end
    // Random control words and comparator inputs
    for (int i = 0; i < 12; i++) begin
      d = 16'($random(seed));
      comparator_above = 1'($random(seed));
      overcurrent_raw = 1'($random(seed));
      wr(CHA_REG_CTRL2, d);
      cyc(4);
      rd_chk(CHA_REG_CTRL2, d);
      `CHK(comparator_ref_high, d[4])
      `CHK(comparator_enable, !d[3])
      `CHK(comparator_output, !d[3] & (comparator_above ^ d[2]))
      `CHK(severe_overcurrent_protection, !d[1])
      `CHK(overcurrent_trip, overcurrent_raw & !d[1])
      `CHK(platform_power_monitor_low_gain, d[0])
    end
    // Every debounce code on both current alerts
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 4; c++) begin
        wr(CHA_REG_CTRL2, 16'(c << 9) | 16'h01c0);
        {discharge_current_cond, input_current_cond} = (ch == 1) ? 2'h2 : 2'h1;
        wait_hi(ch, 2000, n);
        win(n, deb_tab[c], deb_tab[c] + 6);
        {discharge_current_cond, input_current_cond} = 2'h0;
        cyc(10);
      end
    end
    // Short dropout restarts the timer
    wr(CHA_REG_CTRL2, 16'h05c0);
    discharge_current_cond = 1'b1;
    cyc(30);
    discharge_current_cond = 1'b0;
    cyc(1);
    discharge_current_cond = 1'b1;
    wait_hi(1, 2000, n);
    win(n, T500, T500 + 6);
    discharge_current_cond = 1'b0;
    cyc(10);
    // Low-rail ignores the programmed debounce
    wr(CHA_REG_CTRL2, 16'h03c0);
    low_rail_cond = 1'b1;
    wait_hi(2, 2000, n);
    win(n, CHA_T10US_CYC, CHA_T10US_CYC + 6);
    low_rail_cond = 1'b0;
    cyc(10);
    // Minimum throttle duration, every code, cause removed at once
    for (int h = 0; h < 8; h++) begin
      wr(CHA_REG_CTRL2, 16'h0200 | 16'(h << 6));
      input_current_cond = 1'b1;
      wait_hi(0, 100, n);
      input_current_cond = 1'b0;
      wait_hi(5, 10, n);
      `CHK(throttle_alert_n_o, 1'b0)
      wait_hi(6, 400, n);
      win(n, dur_tab[h], dur_tab[h] + 8);
      cyc(5);
    end
    // Gate delay: first insertion fast, then by control bit 11
    wr(CHA_REG_CTRL2, 16'h0000);
    adapter_present = 1'b1;
    wait_hi(3, 400, n);
    win(n, G_FAST, G_FAST + 8);
    adapter_present = 1'b0;
    wait_hi(4, 10, n);
    win(n, 0, 5);
    adapter_present = 1'b1;
    wait_hi(3, 400, n);
    win(n, G_SLOW, G_SLOW + 8);
    adapter_present = 1'b0;
    cyc(6);
    wr(CHA_REG_CTRL2, 16'h0800);
    adapter_present = 1'b1;
    wait_hi(3, 400, n);
    win(n, G_FAST, G_FAST + 8);
    adapter_present = 1'b0;
    cyc(6);
    // Gate in reverse-supply mode
    reverse_supply_mode = 1'b1;
    wr(CHA_REG_CTRL2, 16'h0000);
    cyc(3);
    `CHK(adapter_switch_gate, 1'b1)
    wr(CHA_REG_CTRL2, 16'h0020);
    cyc(3);
    `CHK(adapter_switch_gate, 1'b0)
    reverse_supply_mode = 1'b0;
    cyc(3);
    stop_test();
  end
endmodule // tb_top
